// ==== verilog/rsrc_consts.vh ====
// constants for the remote sensor read control block
// assumes byte-wide register accesses on a single 16-bit address space
`ifndef RSRC_CONSTS_VH
`define RSRC_CONSTS_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define RSRC_ADDR_CMD_STATUS 16'h00fc
`define RSRC_ADDR_READ_HIGH 16'h2602
`define RSRC_ADDR_READ_LOW 16'h2603
`define RSRC_ADDR_SELECT_SIX 16'h2709
`define RSRC_ADDR_SELECT_TWO_FOUR 16'h270a

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RSRC_CMD_HI 4
`define RSRC_CMD_LO 2
`define RSRC_PHASE_HI 1
`define RSRC_PHASE_LO 0
`define RSRC_RD_PERR_BIT 6
`define RSRC_WR_PERR_BIT 5
`define RSRC_SEL2_HI 2
`define RSRC_SEL2_LO 0
`define RSRC_SEL4_HI 6
`define RSRC_SEL4_LO 4
`define RSRC_SEL6_HI 2
`define RSRC_SEL6_LO 0

// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define RSRC_CMD_IDLE 3'h0
`define RSRC_CMD_TRIM 3'h1
`define RSRC_CMD_SENSE 3'h2
`define RSRC_CMD_IGNORED 3'h5
`define RSRC_PHASE_NONE 2'h0
`define RSRC_PHASE_PAIR2 2'h1
`define RSRC_PHASE_PAIR4 2'h2
`define RSRC_PHASE_PAIR6 2'h3
// selection codes, bit 0 is a don't-care
`define RSRC_SEL_GRP_00 2'h0
`define RSRC_SEL_GRP_01 2'h1
`define RSRC_SEL_GRP_10 2'h2
`define RSRC_SEL_GRP_11 2'h3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RSRC_RST_BYTE 8'h00
`define RSRC_RST_WORD 16'h0000

`endif

// ==== verilog/rsrc_format.v ====
// maps the raw 16-bit word returned by a sensor into the read buffer layout
// assumes raw data holds the sensor value right-aligned, first byte in [15:8]
`timescale 1ns/1ps
`include "rsrc_consts.vh"

module rsrc_format (
  input wire [2:0] i_command,
  input wire [2:0] i_select,
  input wire [15:0] i_raw,
  output reg [15:0] o_word
);

  // ------------------------------------------------------------
  // layout per command and selection group
  // ------------------------------------------------------------
  always @* begin
    o_word = i_raw;
    case (i_command)
      `RSRC_CMD_TRIM: begin
        case (i_select[2:1])
          `RSRC_SEL_GRP_00: o_word = {7'h00, i_raw[7:0], 1'b0};
          `RSRC_SEL_GRP_11: o_word = i_raw;
          default: o_word = i_raw;
        endcase
      end
      `RSRC_CMD_SENSE: begin
        case (i_select[2:1])
          `RSRC_SEL_GRP_00: o_word = {{5{i_raw[10]}}, i_raw[10:0]};
          `RSRC_SEL_GRP_01: o_word = {8'h00, i_raw[7:0]};
          `RSRC_SEL_GRP_10: o_word = {i_raw[7:0], 8'h00};
          default: o_word = i_raw;
        endcase
      end
      default: o_word = i_raw;
    endcase
  end

endmodule // rsrc_format

// ==== verilog/rsrc_ctrl.v ====
// remote sensor read control: command register, selection registers,
// transaction sequencing and read buffer for up to three isolated sensors
// assumes a link engine on the same clock that runs the pulse protocol and
// answers each request with one done pulse carrying raw data and parity
//
// Contract
// - a write of command and phase starts a transaction toward the sensor named by the phase.
// - on completion the command sub-field clears and the result lands in the read buffer.
// - the read parity error flag is updated from parity checks during each read.
// - a command write while a read is pending is ignored and the read goes on untouched; the code still applies its parity clear bits.
// - the command field splits into a three-bit command and a two-bit phase.
// - phases 01, 10 and 11 address pin pairs 2-3, 4-5 and 6-7 with their own selection.
// - only commands 001 and 010 start reads, 000 and 101 are ignored, others reserved.
// - command 001 with selection 00x returns the reference trim at buffer bits 8 to 1.
// - command 001 with selection 11x returns two bandgap trim bytes, high then low.
// - command 010 with selection 00x returns an 11-bit temperature, sign extended.
// - command 010 returns supply voltage low for 01x and chip version high for 10x.
// - either parity error flag stays set until software clears it.
`timescale 1ns/1ps
`include "rsrc_consts.vh"

module rsrc_ctrl (
  input wire i_clk,
  input wire i_reset_n,
  // register port
  input wire [15:0] i_addr,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // link engine
  output reg o_xact_req,
  output reg [2:0] o_xact_command,
  output reg [1:0] o_xact_phase,
  output reg [2:0] o_xact_select,
  input wire i_xact_done,
  input wire [15:0] i_xact_data,
  input wire i_xact_read_parity_err,
  input wire i_write_parity_err,
  // configuration seen by the link engine, and the busy flag
  output wire [2:0] o_sensor_enable,
  output wire [1:0] o_sensor_chop,
  output wire o_busy
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_REQ = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] command;
  reg [1:0] phase;
  reg read_perr;
  reg write_perr;
  reg [7:0] select_six;
  reg [7:0] select_two_four;
  reg [15:0] remote_read_buffer;
  reg [2:0] latched_select;
  wire [15:0] formatted;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_cmd = i_wr_en && (i_addr == `RSRC_ADDR_CMD_STATUS);
  wire wr_sel6 = i_wr_en && (i_addr == `RSRC_ADDR_SELECT_SIX);
  wire wr_sel24 = i_wr_en && (i_addr == `RSRC_ADDR_SELECT_TWO_FOUR);
  wire [2:0] wr_command = i_wdata[`RSRC_CMD_HI:`RSRC_CMD_LO];
  wire [1:0] wr_phase = i_wdata[`RSRC_PHASE_HI:`RSRC_PHASE_LO];
  wire pending = (state != ST_IDLE);
  wire cmd_ok = (wr_command == `RSRC_CMD_TRIM) || (wr_command == `RSRC_CMD_SENSE);
  wire phase_ok = (wr_phase != `RSRC_PHASE_NONE);
  // busy writes start nothing so the running transfer keeps its fields; their parity clear bits still act
  wire start = wr_cmd && !pending && cmd_ok && phase_ok;
  wire finish = (state == ST_WAIT) && i_xact_done;

  assign o_busy = pending;
  assign o_sensor_enable = select_six[5:3];
  assign o_sensor_chop = select_six[7:6];

  // ------------------------------------------------------------
  // per-phase selection field
  // ------------------------------------------------------------
  reg [2:0] phase_select;
  always @* begin
    case (wr_phase)
      `RSRC_PHASE_PAIR2: phase_select = select_two_four[`RSRC_SEL2_HI:`RSRC_SEL2_LO];
      `RSRC_PHASE_PAIR4: phase_select = select_two_four[`RSRC_SEL4_HI:`RSRC_SEL4_LO];
      `RSRC_PHASE_PAIR6: phase_select = select_six[`RSRC_SEL6_HI:`RSRC_SEL6_LO];
      default: phase_select = 3'h0;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    case (state)
      ST_IDLE: next_state = start ? ST_REQ : ST_IDLE;
      ST_REQ: next_state = ST_WAIT;
      ST_WAIT: next_state = i_xact_done ? ST_IDLE : ST_WAIT;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      o_xact_req <= 1'b0;
      o_xact_command <= 3'h0;
      o_xact_phase <= 2'h0;
      o_xact_select <= 3'h0;
      latched_select <= 3'h0;
    end else begin
      state <= next_state;
      o_xact_req <= (next_state == ST_REQ);
      if (start) begin
        // selection is sampled at the start, later rewrites do not disturb it
        latched_select <= phase_select;
        o_xact_command <= wr_command;
        o_xact_phase <= wr_phase;
        o_xact_select <= phase_select;
      end
    end
  end

  // ------------------------------------------------------------
  // command and status register
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      command <= `RSRC_CMD_IDLE;
      phase <= `RSRC_PHASE_NONE;
    end else begin
      if (start) begin
        command <= wr_command;
        phase <= wr_phase;
      end else if (finish) begin
        command <= `RSRC_CMD_IDLE;
      end
    end
  end

  // ------------------------------------------------------------
  // sticky parity flags
  // ------------------------------------------------------------
  // writing a 1 leaves a flag alone, so a command write does not lose an
  // error that software has not looked at yet
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      read_perr <= 1'b0;
      write_perr <= 1'b0;
    end else begin
      // hardware set wins over a software clear in the same cycle
      if (finish && i_xact_read_parity_err) begin
        read_perr <= 1'b1;
      end else if (wr_cmd && !i_wdata[`RSRC_RD_PERR_BIT]) begin
        read_perr <= 1'b0;
      end
      if (i_write_parity_err) begin
        write_perr <= 1'b1;
      end else if (wr_cmd && !i_wdata[`RSRC_WR_PERR_BIT]) begin
        write_perr <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // selection registers and read buffer
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      select_six <= `RSRC_RST_BYTE;
      select_two_four <= `RSRC_RST_BYTE;
      remote_read_buffer <= `RSRC_RST_WORD;
    end else begin
      if (wr_sel6)
        select_six <= i_wdata;
      if (wr_sel24)
        select_two_four <= {1'b0, i_wdata[6:4], 1'b0, i_wdata[2:0]};
      if (finish)
        remote_read_buffer <= formatted;
    end
  end

  rsrc_format u_format (
    .i_command(o_xact_command),
    .i_select(latched_select),
    .i_raw(i_xact_data),
    .o_word(formatted)
  );

  // ------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ------------------------------------------------------------
  // bit 7 of the status byte is unused and always reads 0
  wire [7:0] status_byte = {1'b0, read_perr, write_perr, command, phase};
  reg [7:0] next_rdata;
  always @* begin
    case (i_addr)
      `RSRC_ADDR_CMD_STATUS: next_rdata = status_byte;
      `RSRC_ADDR_READ_HIGH: next_rdata = remote_read_buffer[15:8];
      `RSRC_ADDR_READ_LOW: next_rdata = remote_read_buffer[7:0];
      `RSRC_ADDR_SELECT_SIX: next_rdata = select_six;
      `RSRC_ADDR_SELECT_TWO_FOUR: next_rdata = select_two_four;
      default: next_rdata = 8'h00;
    endcase
  end

  // o_rdata holds between reads so a slow poller still sees the last answer
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= `RSRC_RST_BYTE;
    end else if (i_rd_en) begin
      o_rdata <= next_rdata;
    end
  end

endmodule // rsrc_ctrl

// ==== verif/rsrc_link_model.sv ====
// link engine stand-in: one done pulse with word and parity per request
// assumes a one-cycle request pulse on the shared clock
`timescale 1ns/1ps
module rsrc_link_model (
  input wire i_clk,
  input wire i_req,
  input wire [3:0] i_dly,
  input wire [15:0] i_raw,
  input wire i_perr,
  output reg o_done = 1'b0,
  output wire [15:0] o_data,
  output wire o_perr
);
  reg act = 1'b0;
  reg [3:0] cnt = 4'h0;
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_req) begin
      act <= 1'b1;
      cnt <= 4'h0;
    end else if (act) begin
      cnt <= cnt + 4'h1;
      if (cnt == i_dly) begin
        act <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end
  // inverted outside the pulse so a stale sample never matches
  assign o_data = o_done ? i_raw : ~i_raw;
  assign o_perr = o_done ? i_perr : ~i_perr;
endmodule // rsrc_link_model

// ==== verif/rsrc_ctrl_assertions.sv ====
// checker for the remote sensor read control ports
// assumes parity flag reads show the state before the read edge
`timescale 1ns/1ps
module rsrc_ctrl_chk (
  input wire i_clk,
  input wire i_reset_n,
  input wire [15:0] i_addr,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire o_xact_req,
  input wire [2:0] o_xact_command,
  input wire [1:0] o_xact_phase,
  input wire i_xact_done,
  input wire i_xact_read_parity_err,
  input wire i_write_parity_err,
  input wire o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire cw = i_wr_en && i_addr == 16'h00fc;
  wire ok = (i_wdata[4:2] == 3'h1 || i_wdata[4:2] == 3'h2) && i_wdata[1:0] != 2'h0;
  wire sr = i_rd_en && !i_wr_en && i_addr == 16'h00fc;
  wire fin = o_busy && !o_xact_req && i_xact_done;
  reg perr;
  // shadow of the sticky flag: a set wins over a clear
  always @(posedge i_clk) begin
    if (!i_reset_n) perr <= 1'b0;
    else if (fin && i_xact_read_parity_err) perr <= 1'b1;
    else if (cw && !i_wdata[6]) perr <= 1'b0;
  end
  reg wperr;
  always @(posedge i_clk) begin
    if (!i_reset_n) wperr <= 1'b0;
    else if (i_write_parity_err) wperr <= 1'b1;
    else if (cw && !i_wdata[5]) wperr <= 1'b0;
  end
  AST_START: assert property (cw && ok && !o_busy |=> o_xact_req && o_busy &&
    o_xact_command == $past(i_wdata[4:2]) && o_xact_phase == $past(i_wdata[1:0]))
    else $error("start not taken");
  AST_REFUSE: assert property (cw && (o_busy || !ok) |=> !o_xact_req)
    else $error("refused write started a read");
  AST_REQ_ONE: assert property (o_xact_req |=> (!o_xact_req) [*2])
    else $error("request not a single pulse");
  AST_BUSY_RISE: assert property ($rose(o_busy) |-> o_xact_req)
    else $error("busy without request");
  AST_DONE: assert property (fin |=> !o_busy)
    else $error("busy after done");
  AST_HOLD: assert property (o_busy && !i_xact_done |=> o_busy && $stable(o_xact_command))
    else $error("pending read disturbed");
  AST_CLEARED: assert property (sr && !o_busy |=> o_rdata[4:2] == 3'h0 && !o_rdata[7])
    else $error("command field not cleared");
  AST_PERR: assert property (sr |=> o_rdata[6] == $past(perr))
    else $error("read parity flag wrong");
  AST_WPERR: assert property (sr |=> o_rdata[5] == $past(wperr))
    else $error("write parity flag wrong");
  cover property (cw && ok && !o_busy);
  cover property (i_write_parity_err && cw && !i_wdata[5]);
  cover property (fin && i_xact_read_parity_err);
  cover property (cw && o_busy);
endmodule // rsrc_ctrl_chk
bind rsrc_ctrl rsrc_ctrl_chk u_chk (.i_clk, .i_reset_n, .i_addr, .i_wr_en, .i_rd_en,
  .i_wdata, .o_rdata, .o_xact_req, .o_xact_command, .o_xact_phase, .i_xact_done,
  .i_xact_read_parity_err, .i_write_parity_err, .o_busy);

// ==== verif/test_remote_sensor_read_control.sv ====
// self-checking bench: register reads and writes drive every read type
// assumes the link model answers each request after a set delay
`timescale 1ns/1ps
module test_remote_sensor_read_control;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata, st, hi, lo, c;
  logic [2:0] o_xact_command, o_xact_select;
  logic [1:0] o_xact_phase;
  logic o_xact_req, o_busy, done, xperr;
  logic [15:0] xdata, raw = 16'h0000;
  logic [3:0] dly = 4'h1;
  logic perr_in = 1'b0;
  logic pe = 1'b0;
  logic wperr = 1'b0;
  logic [2:0] sen;
  logic [1:0] chop;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_req = 0;
  // address, select, command, raw word, expected buffer
  logic [63:0] tv [6] = '{64'h270a_01_05_ffa5_014a, 64'h270a_60_06_1234_1234,
    64'h2709_01_0b_0455_fc55, 64'h270a_02_09_ff5a_005a, 64'h270a_07_09_beef_beef,
    64'h270a_40_0a_883c_3c00};
  logic [5:0] pv = 6'b000100;
  logic [7:0] bad [4] = '{8'h61, 8'h75, 8'h64, 8'h6d};
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_xact_req === 1'b1) n_req <= n_req + 1;
  rsrc_ctrl i_dut (.i_clk, .i_reset_n, .i_addr, .i_wr_en, .i_rd_en, .i_wdata, .o_rdata,
    .o_xact_req, .o_xact_command, .o_xact_phase, .o_xact_select, .i_xact_done(done),
    .i_xact_data(xdata), .i_xact_read_parity_err(xperr), .i_write_parity_err(wperr),
    .o_sensor_enable(sen), .o_sensor_chop(chop), .o_busy);
  rsrc_link_model u_link (.i_clk, .i_req(o_xact_req), .i_dly(dly), .i_raw(raw),
    .i_perr(perr_in), .o_done(done), .o_data(xdata), .o_perr(xperr));
  // ----
  // register access tasks
  // ----
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1 d = o_rdata;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(16'h00fc, st);
    chk(st, 16'h0000);
    wr(16'h270a, 8'hff);
    rd(16'h270a, st);
    chk(st, 16'h0077);
    rd(16'h2604, st);
    chk(st, 16'h0000);
    wr(16'h2709, 8'he9);
    #1 chk({chop, sen}, 16'h001d);
    rd(16'h2709, st);
    chk(st, 16'h00e9);
    // a link parity error lands on the same edge as a clearing write
    fork
      wr(16'h00fc, 8'h00);
      begin
        @(posedge i_clk);
        wperr <= 1'b1;
        @(posedge i_clk);
        wperr <= 1'b0;
      end
    join
    rd(16'h00fc, st);
    chk(st, 16'h0020);
    wr(16'h00fc, 8'h40);
    rd(16'h00fc, st);
    chk(st, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      c = tv[k][39:32];
      dly <= 4'(2 * k + 1);
      raw <= tv[k][31:16];
      perr_in <= pv[k];
      wr(tv[k][63:48], tv[k][47:40]);
      wr(16'h00fc, c | 8'h60);
      #1 chk(o_xact_select, c[1:0] == 2'h2 ? tv[k][46:44] : tv[k][42:40]);
      chk(o_xact_phase, c[1:0]);
      wr(16'h00fc, 8'h65);
      st = 8'hff;
      for (int i = 0; i < 40 && st[4:2] !== 3'h0; i++) rd(16'h00fc, st);
      pe = pe | pv[k];
      chk(st, {1'b0, pe, 4'h0, c[1:0]});
      rd(16'h2602, hi);
      rd(16'h2603, lo);
      chk({hi, lo}, tv[k][15:0]);
    end
    wr(16'h00fc, 8'h00);
    rd(16'h00fc, st);
    chk(st, 16'h0002);
    for (int j = 0; j < 4; j++) begin
      wr(16'h00fc, bad[j]);
      rd(16'h00fc, st);
      chk(st, 16'h0002);
    end
    rd(16'h2602, hi);
    rd(16'h2603, lo);
    chk({hi, lo}, 16'h3c00);
    chk(16'(n_req), 16'd6);
    results();
  end
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule // test_remote_sensor_read_control
